// ### src/posi_pkg.sv
// package for the plc operating state indicator
package posi_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_EVT = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_MAXCYC = 4'hc;
  // ctrl register fields (write steers the block)
  localparam int CTRL_MULTI = 0;
  localparam int CTRL_REACT = 1;
  localparam int CTRL_PWR_OK = 2;
  localparam int CTRL_INIT_DONE = 3;
  localparam int CTRL_INIT_ERR = 4;
  localparam int CTRL_CYC_START = 5;
  // event register fields (write one pulses the event)
  localparam int EV_REMOTE_STOP = 0;
  localparam int EV_PROG_STOP = 1;
  localparam int EV_USER_STOP = 2;
  localparam int EV_CFG_ERR = 3;
  localparam int EV_MEM_ERR = 4;
  localparam int EV_STACK_OVF = 5;
  localparam int EV_STW = 6;
  localparam int EV_OR_SYS_REQ = 7;
  // status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_TIMEOUT = 8;
  localparam int ST_ADDR = 9;
  localparam int ST_OVERRUN = 10;
  localparam int ST_HARD = 11;
  localparam int ST_ORPEND = 12;
  localparam int ST_COLDREQ = 13;
  // flash timing
  localparam int CLK_HZ = 125_000_000;
  localparam int FAST_HALF_MS = 250;
  localparam int FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam logic [31:0] MAXCYC_RESET = 32'h0773_5940;
  localparam int IO_ADDRS = 256;

  // operating state, one-hot
  typedef enum logic [5:0] {
    POSI_SOFT = 6'h01,
    POSI_HARD = 6'h02,
    POSI_ORQ = 6'h04,
    POSI_INIT = 6'h08,
    POSI_RUN = 6'h10,
    POSI_INITF = 6'h20
  } posi_state_t;

  // switch inputs
  typedef struct packed {
    logic run;
    logic rst_cold;
    logic rst_overall;
  } posi_sw_t;

  // io access report from the cycle engine
  typedef struct packed {
    logic valid;
    logic cold_scan;
    logic direct;
    logic [7:0] addr;
    logic ack;
  } posi_io_t;

  // front panel lamps
  typedef struct packed {
    logic run;
    logic stop;
    logic hard;
    logic init;
    logic timeout;
    logic addr;
    logic overrun;
    logic odis;
  } posi_lamp_t;
endpackage : posi_pkg

// ### src/posi_top.sv
// operating state controller with lamps and output disable
`timescale 1ns/1ps

// What this block does
// - others' stop shows steady stop lamp
// - other cpu programmer stop enters stop
// - overall reset request flashes stop fast
// - pending overall reset refuses any restart
// - cold restart required after an error stop flashes stop slowly
// - unhandled error or config error stops slowly
// - stop switch after error steadies lamp
// - user stop instruction stops, flashes slowly
// - matching error lamp lights steady, without flashing
// - memory, stack, stw errors cause hard stop
// - hard stop cleared only by power cycle
// - unacknowledged direct access lights timeout lamp
// - cold restart marks present modules in track
// - unconfigured image access raises address error
// - cycle overrun lights lamp, stops when unhandled
// - output disable in power events and stop
// - restart lamp lit, flashes on failure
// - two overall reset passes: fast then steady
// - hard fault fails the overall reset
// - cold restart: restart lamp, then run
// - run lamp lit during cyclic processing
module posi_top #(
  parameter int FAST_HALF = posi_pkg::FAST_HALF_CYC,
  parameter int IO_N = posi_pkg::IO_ADDRS
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // operator switches
  input wire posi_pkg::posi_sw_t sw_i,
  // io access reports
  input wire posi_pkg::posi_io_t io_i,
  // lamps and backplane
  output posi_pkg::posi_lamp_t lamp_o,
  output logic output_disable_o
);
  localparam int PW = $clog2(FAST_HALF + 1);

  typedef struct packed {
    posi_pkg::posi_state_t st;
    logic [PW-1:0] pre;
    logic [1:0] ph;
    logic run_d;
    logic remote;
    logic err_stop;
    logic cold_req;
    logic or_pend;
    logic or_fail;
    logic timeout;
    logic addr;
    logic overrun;
    logic [5:0] ctrl;
    logic [31:0] maxcyc;
    logic [31:0] cyc_cnt;
    logic [IO_N-1:0] track;
    logic ack;
    logic [31:0] rdat;
    posi_pkg::posi_lamp_t lamp;
  } posi_regs_t;

  posi_regs_t q_reg;
  posi_regs_t q_next;
  logic wr;
  logic [7:0] ev;
  logic run_rise;
  logic run_fall;
  logic err_any;
  logic hard_ev;
  logic slow_on;
  logic fast_on;

  // byte-lane aware merge
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // bus decode and event decode
  always_comb begin
    // a write lands at the edge where the master sees ack, never earlier
    wr = cyc_i && stb_i && we_i && q_reg.ack;
    ev = (wr && adr_i == posi_pkg::ADDR_EVT && sel_i[0]) ? dat_i[7:0] : 8'h00;
    run_rise = sw_i.run && !q_reg.run_d;
    run_fall = !sw_i.run && q_reg.run_d;
    slow_on = q_reg.ph[1];
    fast_on = q_reg.ph[0];
    hard_ev = ev[posi_pkg::EV_MEM_ERR] || ev[posi_pkg::EV_STACK_OVF]
            || ev[posi_pkg::EV_STW];
  end

  // next state
  always_comb begin
    q_next = q_reg;
    err_any = 1'b0;
    q_next.ack = cyc_i && stb_i && !q_reg.ack;
    q_next.run_d = sw_i.run;
    // one prescaler, fast phase toggles each half, slow every second
    if (q_reg.pre == PW'(FAST_HALF - 1)) begin
      q_next.pre = '0;
      q_next.ph = q_reg.ph + 2'h1;
    end else begin
      q_next.pre = q_reg.pre + PW'(1);
    end
    // register writes
    if (wr && adr_i == posi_pkg::ADDR_CTRL && sel_i[0]) begin
      q_next.ctrl = dat_i[5:0];
    end
    if (wr && adr_i == posi_pkg::ADDR_MAXCYC) begin
      q_next.maxcyc = wmerge(q_reg.maxcyc, dat_i, sel_i);
    end
    // io access checks
    if (io_i.valid) begin
      if (io_i.cold_scan && q_reg.st == posi_pkg::POSI_INIT) begin
        q_next.track[io_i.addr] = io_i.ack;
      end else if (q_reg.st == posi_pkg::POSI_RUN) begin
        if (!io_i.ack && (io_i.direct || (q_reg.track[io_i.addr] && !io_i.addr[7]))) begin
          q_next.timeout = 1'b1;
          err_any = 1'b1;
        end else if (!io_i.direct && !q_reg.track[io_i.addr]) begin
          q_next.addr = 1'b1;
          err_any = 1'b1;
        end
      end
    end
    // scan time watchdog
    if (q_reg.st == posi_pkg::POSI_RUN) begin
      if (q_reg.ctrl[posi_pkg::CTRL_CYC_START]) begin
        q_next.cyc_cnt = '0;
        // a fresh software write of the bit wins over the self-clear
        if (!(wr && adr_i == posi_pkg::ADDR_CTRL && sel_i[0])) begin
          q_next.ctrl[posi_pkg::CTRL_CYC_START] = 1'b0;
        end
      end else if (q_reg.cyc_cnt >= q_reg.maxcyc) begin
        q_next.overrun = 1'b1;
        err_any = 1'b1;
      end else begin
        q_next.cyc_cnt = q_reg.cyc_cnt + 32'h1;
      end
    end
    unique case (q_reg.st)
      posi_pkg::POSI_SOFT: begin
        if (run_rise && sw_i.rst_overall) begin
          q_next.st = posi_pkg::POSI_ORQ;
          q_next.or_fail = 1'b0;
          q_next.or_pend = 1'b1;
        end else if (q_reg.or_pend && run_rise) begin
          q_next.or_pend = 1'b0;
        end else if (run_rise && sw_i.rst_cold) begin
          q_next.st = posi_pkg::POSI_INIT;
          q_next.track = '0;
          q_next.cold_req = 1'b0;
          q_next.err_stop = 1'b0;
          q_next.remote = 1'b0;
          q_next.timeout = 1'b0;
          q_next.addr = 1'b0;
          q_next.overrun = 1'b0;
        end else if (run_fall && q_reg.err_stop) begin
          q_next.err_stop = 1'b0;
        end
        if (ev[posi_pkg::EV_CFG_ERR]) begin
          q_next.err_stop = 1'b1;
          q_next.cold_req = 1'b1;
        end
      end
      posi_pkg::POSI_ORQ: begin
        if (run_rise && sw_i.rst_overall) begin
          q_next.st = posi_pkg::POSI_SOFT;
          q_next.or_pend = 1'b0;
          q_next.cold_req = 1'b1;
          q_next.err_stop = 1'b0;
        end else if (run_rise) begin
          q_next.st = posi_pkg::POSI_SOFT;
          q_next.or_pend = 1'b0;
        end
      end
      posi_pkg::POSI_INIT: begin
        if (q_reg.ctrl[posi_pkg::CTRL_INIT_ERR] || ev[posi_pkg::EV_CFG_ERR]) begin
          q_next.st = posi_pkg::POSI_INITF;
        end else if (q_reg.ctrl[posi_pkg::CTRL_INIT_DONE]) begin
          q_next.st = posi_pkg::POSI_RUN;
          q_next.cyc_cnt = '0;
        end
      end
      posi_pkg::POSI_RUN: begin
        if (run_fall) begin
          q_next.st = posi_pkg::POSI_SOFT;
        end else if (ev[posi_pkg::EV_REMOTE_STOP] || ev[posi_pkg::EV_PROG_STOP]
                     && q_reg.ctrl[posi_pkg::CTRL_MULTI]) begin
          q_next.st = posi_pkg::POSI_SOFT;
          q_next.remote = 1'b1;
        end else if (ev[posi_pkg::EV_USER_STOP] || ev[posi_pkg::EV_CFG_ERR]
                     || (err_any && !q_reg.ctrl[posi_pkg::CTRL_REACT])) begin
          q_next.st = posi_pkg::POSI_SOFT;
          q_next.err_stop = 1'b1;
          q_next.cold_req = 1'b1;
        end
      end
      posi_pkg::POSI_INITF: begin
        if (run_fall) begin
          q_next.st = posi_pkg::POSI_SOFT;
          q_next.cold_req = 1'b1;
        end
      end
      posi_pkg::POSI_HARD: begin
        q_next.st = posi_pkg::POSI_HARD;
      end
      default: q_next.st = posi_pkg::POSI_HARD;
    endcase
    // system request after the case, so a same-cycle clear cannot lose it
    if (ev[posi_pkg::EV_OR_SYS_REQ]) begin
      q_next.or_pend = 1'b1;
    end
    if (hard_ev) begin
      q_next.st = posi_pkg::POSI_HARD;
      q_next.or_fail = q_reg.st == posi_pkg::POSI_ORQ;
    end
    // lamps, all registered
    q_next.lamp.run = q_next.st == posi_pkg::POSI_RUN;
    q_next.lamp.hard = q_next.st == posi_pkg::POSI_HARD;
    q_next.lamp.init = q_next.st == posi_pkg::POSI_INIT
                     || (q_next.st == posi_pkg::POSI_INITF && slow_on);
    if (q_next.st == posi_pkg::POSI_ORQ || (q_next.st == posi_pkg::POSI_SOFT && q_next.or_pend)) begin
      q_next.lamp.stop = fast_on;
    end else if (q_next.st == posi_pkg::POSI_SOFT && q_next.err_stop && !q_next.remote) begin
      q_next.lamp.stop = slow_on;
    end else begin
      q_next.lamp.stop = q_next.st == posi_pkg::POSI_SOFT || q_next.st == posi_pkg::POSI_INITF;
    end
    q_next.lamp.timeout = q_next.timeout;
    q_next.lamp.addr = q_next.addr;
    q_next.lamp.overrun = q_next.overrun;
    // outputs only switched off; module memories are theirs to keep
    q_next.lamp.odis = q_next.st != posi_pkg::POSI_RUN
                     || !q_next.ctrl[posi_pkg::CTRL_PWR_OK];
    // read data
    unique case (adr_i)
      posi_pkg::ADDR_CTRL: q_next.rdat = {26'h0, q_next.ctrl};
      posi_pkg::ADDR_STAT: q_next.rdat = {18'h0, q_reg.cold_req, q_reg.or_pend,
                                q_reg.or_fail, q_reg.overrun, q_reg.addr,
                                q_reg.timeout, 2'h0, q_reg.st};
      posi_pkg::ADDR_MAXCYC: q_next.rdat = q_reg.maxcyc;
      default: q_next.rdat = 32'h0;
    endcase
  end

  // single state register; reset gives soft stop, outputs disabled
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_reg <= '0;
      q_reg.st <= posi_pkg::POSI_SOFT;
      q_reg.maxcyc <= posi_pkg::MAXCYC_RESET;
      q_reg.lamp.stop <= 1'b1;
      q_reg.lamp.odis <= 1'b1;
    end else begin
      q_reg <= q_next;
    end
  end

  assign ack_o = q_reg.ack;
  assign dat_o = q_reg.rdat;
  assign lamp_o = q_reg.lamp;
  assign output_disable_o = q_reg.lamp.odis;

  // hard stop is never left
  hard_stays_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_HARD |=> q_reg.st == posi_pkg::POSI_HARD)
    else $error("hard stop left");
  hard_entry_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    hard_ev |=> lamp_o.hard)
    else $error("hard fault lamp missing");
  run_lamp_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    lamp_o.run |-> q_reg.st == posi_pkg::POSI_RUN && !output_disable_o)
    else $error("run lamp without run");
  odis_stop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st != posi_pkg::POSI_RUN |-> output_disable_o)
    else $error("outputs enabled in stop");
  bus_ack_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack timing");
  user_stop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_RUN && ev[posi_pkg::EV_USER_STOP] && !hard_ev && !run_fall
    |=> q_reg.st == posi_pkg::POSI_SOFT && q_reg.err_stop)
    else $error("user stop not taken");
  overall_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_SOFT && run_rise && sw_i.rst_overall && !hard_ev
    |=> q_reg.st == posi_pkg::POSI_ORQ)
    else $error("overall reset pass missed");
  no_restart_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.or_pend && q_reg.st == posi_pkg::POSI_SOFT |=> q_reg.st != posi_pkg::POSI_INIT)
    else $error("restart with overall reset pending");

  // remote stop request and its steady-lamp outcome
  sequence remote_req_s;
    q_reg.st == posi_pkg::POSI_RUN && ev[posi_pkg::EV_REMOTE_STOP] && !hard_ev && !run_fall
    && !q_reg.or_pend && !ev[posi_pkg::EV_OR_SYS_REQ];
  endsequence
  sequence remote_stop_s;
    q_reg.st == posi_pkg::POSI_SOFT && q_reg.remote && lamp_o.stop;
  endsequence
  remote_steady_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    remote_req_s |=> remote_stop_s)
    else $error("remote stop lamp not steady");
  // outputs stay disabled until power is reported good
  odis_power_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    !q_reg.ctrl[posi_pkg::CTRL_PWR_OK] |-> output_disable_o)
    else $error("outputs enabled without power");
  // overall reset request follows the fast phase
  fast_flash_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_ORQ |-> lamp_o.stop == $past(q_reg.ph[0]))
    else $error("stop lamp not fast");
  // restart in progress: restart lamp on, stop lamp off
  init_lamp_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_INIT |-> lamp_o.init && !lamp_o.stop)
    else $error("restart lamps wrong");
  // failed restart flashes the restart lamp slowly
  init_flash_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_INITF |-> lamp_o.init == $past(q_reg.ph[1]))
    else $error("restart lamp not flashing");
  // hard stop keeps its lamp and the outputs off
  hard_lamp_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_HARD |-> lamp_o.hard && output_disable_o)
    else $error("hard stop lamp missing");
  // unacknowledged direct access raises timeout
  direct_to_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_RUN && io_i.valid && !io_i.cold_scan && io_i.direct
    && !io_i.ack |=> q_reg.timeout && lamp_o.timeout)
    else $error("timeout not raised");
  // unconfigured image address raises addressing error
  addr_err_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_RUN && io_i.valid && !io_i.cold_scan && !io_i.direct
    && io_i.ack && !q_reg.track[io_i.addr] |=> q_reg.addr && lamp_o.addr)
    else $error("address error not raised");
  // cold scan records presence in the track
  track_mark_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_INIT && io_i.valid && io_i.cold_scan
    |=> q_reg.track[$past(io_i.addr)] == $past(io_i.ack))
    else $error("presence not tracked");
  // scan watchdog expiry lights the overrun lamp
  overrun_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_RUN && !q_reg.ctrl[posi_pkg::CTRL_CYC_START]
    && q_reg.cyc_cnt >= q_reg.maxcyc |=> q_reg.overrun && lamp_o.overrun)
    else $error("overrun not raised");
  // hard fault during overall reset marks it failed
  or_fail_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.st == posi_pkg::POSI_ORQ && hard_ev |=> q_reg.or_fail && lamp_o.hard)
    else $error("overall reset failure missed");
  // timeout flag latches while running
  timeout_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q_reg.timeout && q_reg.st == posi_pkg::POSI_RUN |=> q_reg.timeout)
    else $error("timeout flag lost");
endmodule : posi_top

// ### bench/posi_io_model.sv
// backplane io module model answering process image accesses
`timescale 1ns/1ps
module posi_io_model (
  // clock and requests from the bench
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic cold_i,
  input wire logic dir_i,
  input wire logic [7:0] addr_i,
  input wire logic odis_i,
  // access report and one digital output
  output posi_pkg::posi_io_t io_o,
  output logic dout_o
);
  logic [255:0] present_reg = '1;
  logic [7:0] mem_reg = 8'h00;
  // a module only acknowledges while it is plugged in
  always_ff @(posedge clk_i) begin
    io_o <= {req_i, cold_i, dir_i, addr_i, req_i & present_reg[addr_i]};
    if (req_i) begin
      mem_reg <= addr_i; // never cleared by disable
    end
  end
  // disable forces the output off, memory stays
  assign dout_o = mem_reg[0] & ~odis_i;
endmodule : posi_io_model

// ### bench/posi_top_test.sv
// self-checking bench for the operating state controller
`timescale 1ns/1ps
module posi_top_test;
  localparam int FH = 4;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic ack_o, output_disable_o, dout;
  logic req = 1'b0, cold = 1'b0, dir = 1'b0;
  logic [7:0] ioa = 8'h00;
  posi_pkg::posi_sw_t sw = '0;
  posi_pkg::posi_io_t io;
  posi_pkg::posi_lamp_t lamp;
  int errors = 0, n_checks = 0, seed = 32'h5c2b6320, t;
  logic [5:0] exp_state;
  logic [31:0] rv;

  posi_top #(.FAST_HALF(FH)) dut_u (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .sw_i(sw), .io_i(io), .lamp_o(lamp),
    .output_disable_o(output_disable_o));
  posi_io_model io_u (.clk_i(clk_sys_i), .req_i(req), .cold_i(cold), .dir_i(dir),
    .addr_i(ioa), .odis_i(output_disable_o), .io_o(io), .dout_o(dout));

  // 125 MHz
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
    n_checks++;
    if (got !== ex) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
    if (k >= 50) begin
      errors++;
      finish_test();
    end
  endtask : wb

  // read status and compare the state field with the model
  task automatic st();
    repeat (4) @(posedge clk_sys_i);
    wb(1'b0, posi_pkg::ADDR_STAT, 32'h0);
    chk("state", q[5:0], exp_state);
  endtask : st

  // stop then run with the reset switch in a given position
  task automatic turn(input logic c, input logic o);
    @(posedge clk_sys_i);
    sw <= {1'b0, c, o};
    repeat (3) @(posedge clk_sys_i);
    sw.run <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask : turn

  // toggles of the stop lamp over 64 cycles
  task automatic cnt();
    logic p;
    t = 0;
    p = lamp.stop;
    repeat (64) begin
      @(posedge clk_sys_i);
      if (lamp.stop !== p) t++;
      p = lamp.stop;
    end
  endtask : cnt

  task automatic acc(input logic c, input logic d, input logic [7:0] a);
    @(posedge clk_sys_i);
    req <= 1'b1; cold <= c; dir <= d; ioa <= a;
    @(posedge clk_sys_i);
    req <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask : acc

  initial begin
    repeat (10) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    exp_state = 6'h01;
    chk("stop lamp", lamp.stop, 1'b1);
    chk("odis", output_disable_o, 1'b1);
    st();
    wb(1'b0, posi_pkg::ADDR_MAXCYC, 32'h0);
    chk("maxcyc", q, posi_pkg::MAXCYC_RESET);
    rv = $random(seed);
    wb(1'b1, posi_pkg::ADDR_MAXCYC, rv);
    wb(1'b0, posi_pkg::ADDR_MAXCYC, 32'h0);
    chk("maxcyc wr", q, rv);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, posi_pkg::ADDR_CTRL, 32'h4);
    // first overall reset pass, then a refused cold restart
    turn(1'b0, 1'b1);
    exp_state = 6'h04;
    st();
    chk("or pend", q[posi_pkg::ST_ORPEND], 1'b1);
    cnt();
    chk("fast", t >= 15 && t <= 17, 1'b1);
    turn(1'b1, 1'b0);
    exp_state = 6'h01;
    st();
    chk("no restart", q[5:0] !== 6'h08 && q[5:0] !== 6'h10, 1'b1);
    turn(1'b0, 1'b1);
    turn(1'b0, 1'b1);
    st();
    cnt();
    chk("steady", t, 0);
    chk("steady lit", lamp.stop, 1'b1);
    // cold restart with one module found
    turn(1'b1, 1'b0);
    exp_state = 6'h08;
    st();
    chk("init lamp", lamp.init & ~lamp.stop, 1'b1);
    acc(1'b1, 1'b0, 8'h05);
    sw.rst_cold <= 1'b0;
    wb(1'b1, posi_pkg::ADDR_CTRL, 32'h0e);
    exp_state = 6'h10;
    st();
    chk("run lamp", {lamp.run, lamp.init, output_disable_o}, 3'b100);
    // accesses with an error reaction programmed
    acc(1'b0, 1'b1, 8'hc8);
    io_u.present_reg[8'hc8] = 1'b0;
    acc(1'b0, 1'b1, 8'hc8);
    chk("timeout lamp", lamp.timeout, 1'b1);
    acc(1'b0, 1'b0, 8'h09);
    chk("addr lamp", lamp.addr, 1'b1);
    wb(1'b1, posi_pkg::ADDR_CTRL, 32'h04);
    wb(1'b1, posi_pkg::ADDR_EVT, 32'h04);
    exp_state = 6'h01;
    st();
    cnt();
    chk("slow", t >= 7 && t <= 9, 1'b1);
    chk("odis stop", output_disable_o, 1'b1);
    sw.run <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    cnt();
    chk("steady stop", t, 0);
    chk("stop lit", lamp.stop, 1'b1);
    wb(1'b1, posi_pkg::ADDR_EVT, 32'h10);
    exp_state = 6'h02;
    st();
    chk("hard lamp", lamp.hard, 1'b1);
    turn(1'b1, 1'b0);
    st();
    // power cycle: only a reset leaves hard stop
    sw <= '0;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    exp_state = 6'h01;
    st();
    turn(1'b1, 1'b0);
    wb(1'b1, posi_pkg::ADDR_CTRL, 32'h0d);
    exp_state = 6'h10;
    st();
    wb(1'b1, posi_pkg::ADDR_EVT, 32'h02);
    exp_state = 6'h01;
    st();
    cnt();
    chk("remote stop", {lamp.stop, t == 0}, 2'b11);
    finish_test();
  end

  // a hang ends the run as a failure
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    errors++;
    finish_test();
  end
endmodule : posi_top_test
